// [rtl/spsel_consts.svh]
// What this block does
// - Four-bit select field, bits 7:4, resets to 0x5, kept in non-volatile store
// - Codes 0 and 1 give primary or secondary reference loss of signal
// - Codes 2 and 5 give first or second synthesizer loss of lock
// - Codes 3 and 6 give reference divider halved, valid when not bypassed
// - Codes 4 and 7 give feedback divider output halved
// - Any active test setting overrides select and polarity
// - Status pin 0 shared between indicator and diagnostic sources
// - Codes 8 to 15 give calibration, interrupt, dividers, memory, switches
// - Polarity bit 3 resets to 1; one is active high, zero active low
`ifndef SPSEL_CONSTS_SVH
`define SPSEL_CONSTS_SVH
// ********************************
// Register map
// ********************************
`define SPSEL_IDX_CTRL 8'h1B
`define SPSEL_IDX_TEST 8'h40
`define SPSEL_IDX_NVM 8'h41
`define SPSEL_IDX_IRQ_STAT 8'h42
`define SPSEL_IDX_IRQ_MASK 8'h43
`define SPSEL_ADDR_MSB 9
`define SPSEL_ADDR_LSB 2
// ********************************
// Fields and reset values
// ********************************
`define SPSEL_SEL_MSB 7
`define SPSEL_SEL_LSB 4
`define SPSEL_POL_BIT 3
`define SPSEL_SEL_RST 4'h5
`define SPSEL_POL_RST 1'h1
`define SPSEL_CTRL_RST 8'h58
`define SPSEL_TEST_EN_BIT 0
`define SPSEL_TEST_VAL_BIT 1
`define SPSEL_NVM_SAVE_BIT 0
`define SPSEL_NVM_LOAD_BIT 1
`define SPSEL_IRQ_SEL_BIT 0
`define SPSEL_IRQ_NVM_BIT 1
`define SPSEL_IRQ_BITS 2
`endif

// [rtl/spsel_pkg.sv]
`default_nettype none
package spsel_pkg;
   // Internal indicators that may be routed to the pin
   typedef struct packed {
      logic pri_los;
      logic sec_los;
      logic syn1_lol;
      logic syn2_lol;
      logic syn1_ref_div;
      logic syn2_ref_div;
      logic syn1_ref_bypass;
      logic syn2_ref_bypass;
      logic syn1_fb_div;
      logic syn2_fb_div;
      logic syn1_cal;
      logic syn2_cal;
      logic irq_comb;
      logic syn1_m_div;
      logic syn2_m_div;
      logic syn1_m_bypass;
      logic syn2_m_bypass;
      logic nvm_busy;
      logic syn1_auto_sw;
      logic syn2_auto_sw;
   } spsel_src_type;

   typedef enum logic [3:0] {
      SPSEL_PRI_LOS, SPSEL_SEC_LOS, SPSEL_S1_LOL, SPSEL_S1_REF,
      SPSEL_S1_FB, SPSEL_S2_LOL, SPSEL_S2_REF, SPSEL_S2_FB,
      SPSEL_S1_CAL, SPSEL_S2_CAL, SPSEL_IRQ, SPSEL_S1_M,
      SPSEL_S2_M, SPSEL_NVM, SPSEL_S1_SW, SPSEL_S2_SW
   } spsel_code_type;

   // Non-volatile store handshake
   typedef enum logic [1:0] {
      SPSEL_NV_IDLE, SPSEL_NV_SAVE, SPSEL_NV_LOAD
   } spsel_nv_state_type;
endpackage
`default_nettype wire

// [rtl/spsel_halver.sv]
`default_nettype none
`include "spsel_consts.svh"
// Synchronises a divider output and toggles on each rising edge
module spsel_halver
   import spsel_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic div_in,
   input wire logic bypass,
   output logic half_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic half_q;
   // Two-stage synchroniser, third stage for the edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= div_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // Divide by two; held low while bypassed, output meaningless then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_q <= 1'b0;
      end else if (bypass) begin
         half_q <= 1'b0;
      end else if (s2_q && !s3_q) begin
         half_q <= ~half_q;
      end
   end
   assign half_out = half_q;
endmodule
`default_nettype wire

// [rtl/spsel_top.sv]
// Design decision made here: the APB interface to the registers.
`default_nettype none
`include "spsel_consts.svh"
module spsel_top
   import spsel_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire spsel_src_type src,
   output logic nvm_save,
   output logic nvm_load,
   input wire logic nvm_done,
   input wire logic [7:0] nvm_rdata,
   output logic status_pin0,
   output logic irq
);
   // ********************************
   // Input synchronisers
   // ********************************
   spsel_src_type src1_q;
   spsel_src_type src2_q;
   logic done1_q;
   logic done2_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src1_q <= '0;
         src2_q <= '0;
         done1_q <= 1'b0;
         done2_q <= 1'b0;
      end else begin
         src1_q <= src;
         src2_q <= src1_q;
         done1_q <= nvm_done;
         done2_q <= done1_q;
      end
   end

   // ********************************
   // Divided clocks
   // ********************************
   logic h_s1_ref;
   logic h_s2_ref;
   logic h_s1_fb;
   logic h_s2_fb;
   logic h_s1_m;
   logic h_s2_m;
   spsel_halver u_s1_ref (
      .pclk(pclk),
      .presetn(presetn),
      .div_in(src.syn1_ref_div),
      .bypass(src2_q.syn1_ref_bypass),
      .half_out(h_s1_ref)
   );
   spsel_halver u_s2_ref (
      .pclk(pclk),
      .presetn(presetn),
      .div_in(src.syn2_ref_div),
      .bypass(src2_q.syn2_ref_bypass),
      .half_out(h_s2_ref)
   );
   // Feedback dividers have no bypass, so their halvers never hold
   spsel_halver u_s1_fb (
      .pclk(pclk),
      .presetn(presetn),
      .div_in(src.syn1_fb_div),
      .bypass(1'b0),
      .half_out(h_s1_fb)
   );
   spsel_halver u_s2_fb (
      .pclk(pclk),
      .presetn(presetn),
      .div_in(src.syn2_fb_div),
      .bypass(1'b0),
      .half_out(h_s2_fb)
   );
   spsel_halver u_s1_m (
      .pclk(pclk),
      .presetn(presetn),
      .div_in(src.syn1_m_div),
      .bypass(src2_q.syn1_m_bypass),
      .half_out(h_s1_m)
   );
   spsel_halver u_s2_m (
      .pclk(pclk),
      .presetn(presetn),
      .div_in(src.syn2_m_div),
      .bypass(src2_q.syn2_m_bypass),
      .half_out(h_s2_m)
   );

   // ********************************
   // APB decode
   // ********************************
   logic [7:0] idx;
   logic wr_acc;
   logic mapped;
   logic wr_ctrl;
   logic wr_test;
   logic wr_nvm;
   logic wr_ist;
   logic wr_imask;
   assign idx = paddr[`SPSEL_ADDR_MSB:`SPSEL_ADDR_LSB];
   assign wr_acc = psel && penable && pwrite;
   // Register hit test, shared by the write strobes
   function automatic logic reg_hit(input logic [7:0] index,
                                    input logic [7:0] want);
      reg_hit = (index == want);
   endfunction
   // Per-register write strobes; an unmapped index matches none
   assign wr_ctrl = wr_acc && reg_hit(idx, `SPSEL_IDX_CTRL);
   assign wr_test = wr_acc && reg_hit(idx, `SPSEL_IDX_TEST);
   assign wr_nvm = wr_acc && reg_hit(idx, `SPSEL_IDX_NVM);
   assign wr_ist = wr_acc && reg_hit(idx, `SPSEL_IDX_IRQ_STAT);
   assign wr_imask = wr_acc && reg_hit(idx, `SPSEL_IDX_IRQ_MASK);
   // Zero-wait slave: every access completes in its first access cycle
   assign pready = 1'b1;
   always_comb begin
      unique case (idx)
         `SPSEL_IDX_CTRL, `SPSEL_IDX_TEST, `SPSEL_IDX_NVM,
         `SPSEL_IDX_IRQ_STAT, `SPSEL_IDX_IRQ_MASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !mapped;

   // ********************************
   // Control register
   // ********************************
   logic [3:0] sel_q;
   logic pol_q;
   logic [1:0] test_q;
   spsel_nv_state_type nv_q;
   logic nv_load_done;
   assign nv_load_done = (nv_q == SPSEL_NV_LOAD) && done2_q;
   // Store reload wins: it restores the retained value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= `SPSEL_SEL_RST;
         pol_q <= `SPSEL_POL_RST;
      end else if (nv_load_done) begin
         sel_q <= nvm_rdata[`SPSEL_SEL_MSB:`SPSEL_SEL_LSB];
         pol_q <= nvm_rdata[`SPSEL_POL_BIT];
      end else if (wr_ctrl) begin
         sel_q <= pwdata[`SPSEL_SEL_MSB:`SPSEL_SEL_LSB];
         pol_q <= pwdata[`SPSEL_POL_BIT];
      end
   end

   // Test override setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_q <= 2'h0;
      end else if (wr_test) begin
         test_q <= pwdata[1:0];
      end
   end

   // ********************************
   // Non-volatile store sequencer
   // ********************************
   logic nv_start_save;
   logic nv_start_load;
   logic nv_finish;
   logic nv_quiet;
   assign nv_start_save = wr_nvm && pwdata[`SPSEL_NVM_SAVE_BIT];
   assign nv_start_load = wr_nvm && pwdata[`SPSEL_NVM_LOAD_BIT];
   // Done of a finished transfer drains through the synchroniser for
   // two edges; a start inside that time would end at once, so refuse
   assign nv_quiet = !done1_q && !done2_q;
   assign nv_finish = (nv_q != SPSEL_NV_IDLE) && done2_q;
   // Save takes priority if both are requested together
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nv_q <= SPSEL_NV_IDLE;
      end else begin
         unique case (nv_q)
            SPSEL_NV_IDLE: begin
               if (nv_start_save && nv_quiet) begin
                  nv_q <= SPSEL_NV_SAVE;
               end else if (nv_start_load && nv_quiet) begin
                  nv_q <= SPSEL_NV_LOAD;
               end
            end
            SPSEL_NV_SAVE, SPSEL_NV_LOAD: begin
               if (done2_q) begin
                  nv_q <= SPSEL_NV_IDLE;
               end
            end
            default: nv_q <= SPSEL_NV_IDLE;
         endcase
      end
   end
   assign nvm_save = (nv_q == SPSEL_NV_SAVE);
   assign nvm_load = (nv_q == SPSEL_NV_LOAD);

   // ********************************
   // Source selection and pin
   // ********************************
   logic sel_raw;
   always_comb begin
      unique case (spsel_code_type'(sel_q))
         SPSEL_PRI_LOS: sel_raw = src2_q.pri_los;
         SPSEL_SEC_LOS: sel_raw = src2_q.sec_los;
         SPSEL_S1_LOL: sel_raw = src2_q.syn1_lol;
         SPSEL_S2_LOL: sel_raw = src2_q.syn2_lol;
         SPSEL_S1_REF: sel_raw = h_s1_ref;
         SPSEL_S2_REF: sel_raw = h_s2_ref;
         SPSEL_S1_FB: sel_raw = h_s1_fb;
         SPSEL_S2_FB: sel_raw = h_s2_fb;
         SPSEL_S1_CAL: sel_raw = src2_q.syn1_cal;
         SPSEL_S2_CAL: sel_raw = src2_q.syn2_cal;
         SPSEL_IRQ: sel_raw = src2_q.irq_comb;
         SPSEL_S1_M: sel_raw = h_s1_m;
         SPSEL_S2_M: sel_raw = h_s2_m;
         SPSEL_NVM: sel_raw = src2_q.nvm_busy;
         SPSEL_S1_SW: sel_raw = src2_q.syn1_auto_sw;
         SPSEL_S2_SW: sel_raw = src2_q.syn2_auto_sw;
      endcase
   end

   // Registered pin; test drive bypasses select and polarity
   logic pin_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= 1'b0;
      end else if (test_q[`SPSEL_TEST_EN_BIT]) begin
         pin_q <= test_q[`SPSEL_TEST_VAL_BIT];
      end else begin
         pin_q <= pol_q ? sel_raw : ~sel_raw;
      end
   end
   assign status_pin0 = pin_q;

   // ********************************
   // Interrupts
   // ********************************
   logic [1:0] ist_q;
   logic [1:0] imask_q;
   logic [1:0] ev;
   logic sel_raw_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_raw_q <= 1'b0;
      end else begin
         sel_raw_q <= sel_raw;
      end
   end
   // Rise of chosen indicator; end of a store transfer
   assign ev[`SPSEL_IRQ_SEL_BIT] = sel_raw && !sel_raw_q;
   assign ev[`SPSEL_IRQ_NVM_BIT] = nv_finish;
   // Set beats write-one-to-clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= 2'h0;
      end else if (wr_ist) begin
         ist_q <= (ist_q & ~pwdata[1:0]) | ev;
      end else begin
         ist_q <= ist_q | ev;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imask_q <= 2'h0;
      end else if (wr_imask) begin
         imask_q <= pwdata[1:0];
      end
   end
   assign irq = |(ist_q & imask_q);

   // ********************************
   // Read data
   // ********************************
   logic rd_setup;
   logic [31:0] prdata_d;
   logic [31:0] prdata_q;
   // Word picked in the setup cycle so the bus sees a flip-flop; it
   // shows state as of that cycle, one edge older than the access
   assign rd_setup = psel && !penable && !pwrite;
   always_comb begin
      prdata_d = 32'h0000_0000;
      if (rd_setup) begin
         unique case (idx)
            `SPSEL_IDX_CTRL: prdata_d = {24'h000000, sel_q, pol_q, 3'h0};
            `SPSEL_IDX_TEST: prdata_d = {30'h0, test_q};
            `SPSEL_IDX_NVM: prdata_d = {30'h0, nvm_load, nvm_save};
            `SPSEL_IDX_IRQ_STAT: prdata_d = {30'h0, ist_q};
            `SPSEL_IDX_IRQ_MASK: prdata_d = {30'h0, imask_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end
   // Zero again after the access edge, so idle cycles read zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end
   assign prdata = prdata_q;
endmodule
`default_nettype wire

// [bench/spsel_top_props.sv]
`default_nettype none
`include "spsel_consts.svh"
module spsel_top_props
   import spsel_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire spsel_src_type src,
   input wire logic nvm_save,
   input wire logic nvm_load,
   input wire logic nvm_done,
   input wire logic [7:0] nvm_rdata,
   input wire logic status_pin0,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // Shadow of settings
   // ****
   logic acc;
   logic wr;
   logic [3:0] sel_q;
   logic pol_q;
   logic ten_q;
   logic tval_q;
   logic known_q;
   logic [2:0] calm_q;
   logic [1:0] lvl;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   // Level sources only; halved clocks are checked by the bench
   function automatic logic [1:0] pick(input logic [3:0] c,
                                       input spsel_src_type s);
      case (c)
         4'h0: pick = {1'b1, s.pri_los};
         4'h1: pick = {1'b1, s.sec_los};
         4'h2: pick = {1'b1, s.syn1_lol};
         4'h5: pick = {1'b1, s.syn2_lol};
         4'h8: pick = {1'b1, s.syn1_cal};
         4'h9: pick = {1'b1, s.syn2_cal};
         4'hA: pick = {1'b1, s.irq_comb};
         4'hD: pick = {1'b1, s.nvm_busy};
         4'hE: pick = {1'b1, s.syn1_auto_sw};
         4'hF: pick = {1'b1, s.syn2_auto_sw};
         default: pick = 2'h0;
      endcase
   endfunction
   assign lvl = pick(sel_q, src);
   // A store load makes the shadow unknown until rewritten
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= 4'h5;
         pol_q <= 1'h1;
         ten_q <= 1'h0;
         tval_q <= 1'h0;
         known_q <= 1'h1;
      end else begin
         if (nvm_load) begin
            known_q <= 1'h0;
         end else if (wr && paddr[9:2] == `SPSEL_IDX_CTRL) begin
            sel_q <= pwdata[7:4];
            pol_q <= pwdata[3];
            known_q <= 1'h1;
         end
         if (wr && paddr[9:2] == `SPSEL_IDX_TEST) begin
            ten_q <= pwdata[0];
            tval_q <= pwdata[1];
         end
      end
   end
   // Cycles since anything feeding the pin moved; covers sync delay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         calm_q <= 3'h0;
      end else if (wr || nvm_load || !$stable(src)) begin
         calm_q <= 3'h0;
      end else if (calm_q != 3'h7) begin
         calm_q <= calm_q + 3'h1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   zero_wait_a: assert property (acc |-> pready)
      else $error("pready low in access");
   idle_quiet_a: assert property (!acc |-> prdata == 32'h0 && !pslverr)
      else $error("bus outputs active outside access");
   unmapped_err_a: assert property (
      acc && paddr[9:2] == 8'h00 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   ctrl_read_a: assert property (
      acc && !pwrite && known_q && paddr[9:2] == `SPSEL_IDX_CTRL
      |-> prdata == {24'h0, sel_q, pol_q, 3'h0})
      else $error("control readback wrong");
   pin_level_a: assert property (
      calm_q == 3'h7 && known_q && !ten_q && lvl[1]
      |-> status_pin0 == (lvl[0] ~^ pol_q))
      else $error("pin does not follow selected source");
   pin_test_a: assert property (
      calm_q == 3'h7 && ten_q |-> status_pin0 == tval_q)
      else $error("test override not on pin");
   store_excl_a: assert property (!(nvm_save && nvm_load))
      else $error("save and load together");
   save_start_a: assert property (
      $rose(nvm_save) |-> $past(wr && paddr[9:2] == `SPSEL_IDX_NVM))
      else $error("save without request");
   store_end_a: assert property (
      $rose(nvm_done) |-> ##[1:6] !nvm_save && !nvm_load)
      else $error("store transfer not ended");
   cover property (calm_q == 3'h7 && ten_q);
   cover property ($rose(nvm_load));
   cover property (irq);
endmodule
`default_nettype wire

// [bench/spsel_store_model.sv]
`default_nettype none
module spsel_store_model
   import spsel_pkg::*;
#(
   parameter logic [7:0] STORED = 8'hA8,
   parameter int LAT = 6
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic nvm_save,
   input wire logic nvm_load,
   output logic nvm_done,
   output logic [7:0] nvm_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   logic [7:0] pat_q;
   // Busy time per transfer; done holds until the request drops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
      end else if (nvm_save || nvm_load) begin
         cnt <= cnt + 1;
      end else begin
         cnt <= 0;
      end
   end
   // Moving junk when idle, so stale data never looks valid
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pat_q <= 8'h00;
      end else begin
         pat_q <= pat_q + 8'h35;
      end
   end
   assign nvm_done = (cnt >= LAT);
   assign nvm_rdata = nvm_done ? STORED : pat_q;
endmodule
`default_nettype wire

// [bench/spsel_top_test.sv]
`default_nettype none
`include "spsel_consts.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   fail_count++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module spsel_top_test
   import spsel_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, nvm_save, nvm_load, nvm_done;
   logic status_pin0, irq, er, p0, ia;
   logic [7:0] nvm_rdata;
   spsel_src_type src = '0;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [3:0] lv_code [10] = '{0, 1, 2, 5, 8, 9, 10, 13, 14, 15};
   int lv_bit [10] = '{19, 18, 17, 16, 9, 8, 7, 2, 1, 0};
   logic [3:0] dv_code [6] = '{3, 4, 6, 7, 11, 12};
   int dv_bit [6] = '{15, 11, 14, 10, 6, 5};
   spsel_top spsel_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .src, .nvm_save,
      .nvm_load, .nvm_done, .nvm_rdata, .status_pin0, .irq);
   spsel_store_model #(.STORED(8'hA8), .LAT(6)) spsel_store_model_i (
      .pclk, .presetn, .nvm_save, .nvm_load, .nvm_done, .nvm_rdata);
   always #50 pclk = ~pclk;
   // ****
   // Bus and run control
   // ****
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Read data taken at the edge that sees pready
   task automatic apb(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'h0, i, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Hang guard, far above the expected run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // ****
   // Scenarios
   // ****
   initial begin
      tick(2);
      presetn <= 1'b1;
      apb(0, `SPSEL_IDX_CTRL, 0);
      `CHK("ctrl reset", 32'h58, rd)
      apb(0, 8'h00, 0);
      `CHK("unmapped", 33'h100000000, {er, rd})
      apb(1, `SPSEL_IDX_CTRL, 32'hFF);
      apb(0, `SPSEL_IDX_CTRL, 0);
      `CHK("ctrl rw", 32'hF8, rd)
      foreach (lv_code[i]) for (int p = 0; p < 2; p++) begin
         apb(1, `SPSEL_IDX_CTRL, 32'({lv_code[i], p[0], 3'h0}));
         for (int v = 0; v < 2; v++) begin
            src <= spsel_src_type'(20'(v) << lv_bit[i]);
            tick(5);
            `CHK("level", v[0] ~^ p[0], status_pin0)
         end
      end
      foreach (dv_code[i]) begin
         apb(1, `SPSEL_IDX_CTRL, 32'({dv_code[i], 4'h8}));
         src <= '0;
         tick(5);
         p0 = status_pin0;
         for (int k = 1; k <= 3; k++) begin
            src <= spsel_src_type'(20'h1 << dv_bit[i]);
            tick(8);
            src <= '0;
            tick(8);
            `CHK("halved", p0 ^ k[0], status_pin0)
         end
      end
      apb(1, `SPSEL_IDX_CTRL, 32'h38);
      src <= spsel_src_type'(20'h0A000);
      tick(8);
      `CHK("bypassed", 1'b0, status_pin0)
      for (int t = 0; t < 2; t++) begin
         apb(1, `SPSEL_IDX_CTRL, 32'({4'h0, ~t[0], 3'h0}));
         src <= spsel_src_type'(20'h80000);
         apb(1, `SPSEL_IDX_TEST, 32'(1 + 2 * t));
         tick(5);
         `CHK("override", t[0], status_pin0)
      end
      apb(1, `SPSEL_IDX_TEST, 0);
      apb(1, `SPSEL_IDX_IRQ_STAT, 32'h3);
      src <= '0;
      tick(5);
      src <= spsel_src_type'(20'h80000);
      tick(5);
      apb(0, `SPSEL_IDX_IRQ_STAT, 0);
      `CHK("event", 32'h1, rd)
      // Let the access edge pass before looking at irq
      apb(1, `SPSEL_IDX_IRQ_MASK, 32'h0);
      tick(1);
      ia = irq;
      apb(1, `SPSEL_IDX_IRQ_MASK, 32'h3);
      tick(1);
      `CHK("mask", 1'b1, ia ^ irq)
      apb(1, `SPSEL_IDX_IRQ_STAT, 32'h1);
      tick(1);
      `CHK("clear", 1'b0, irq)
      apb(1, `SPSEL_IDX_NVM, 32'h1);
      apb(0, `SPSEL_IDX_NVM, 0);
      `CHK("save busy", 32'h1, rd)
      tick(12);
      apb(0, `SPSEL_IDX_IRQ_STAT, 0);
      `CHK("save done", 32'h2, rd)
      apb(1, `SPSEL_IDX_NVM, 32'h2);
      tick(12);
      apb(0, `SPSEL_IDX_CTRL, 0);
      `CHK("load", 32'hA8, rd)
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      apb(0, `SPSEL_IDX_CTRL, 0);
      `CHK("reset again", 32'h58, rd)
      tally_and_finish();
   end
endmodule
bind spsel_top spsel_top_props spsel_top_props_i (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .src,
   .nvm_save, .nvm_load, .nvm_done, .nvm_rdata, .status_pin0, .irq);
`default_nettype wire
